// >>> design/dpce_pkg.sv
// Package for the debug probe detect and chip erase block
package dpce_pkg;
	localparam logic        DONE_RESET     = 1'b1;
	localparam logic        PRESENT_RESET  = 1'b0;
	localparam logic        LOCK_RESET     = 1'b1;
	localparam int unsigned CLR_WIDTH      = 8;
	localparam int unsigned CLOCK_MHZ      = 250;
	localparam int unsigned MIN_HOLD_NS    = 8;
	localparam logic [CLR_WIDTH-1:0] MIN_HOLD_CYC =
		CLR_WIDTH'((MIN_HOLD_NS * CLOCK_MHZ + 999) / 1000);
	typedef enum logic [1:0] {
		DPCE_IDLE,
		DPCE_VOLATILE,
		DPCE_FLASH,
		DPCE_DONE
	} dpce_state_t;
endpackage

// >>> design/dpce_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dpce_sync (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_en_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_q;
	logic sync_q;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (clk_en_i) begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> design/dpce_top.sv
// Probe detection and chip erase sequencer
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Hot or cold attach marks probe present
// RULE2: Attach sets probe_attached_flag in secondary_status
// RULE3: Locked device ignores hot-plug attach
// RULE4: No detection before power-on reset releases
// RULE5: Locked: debugger cold-plugs, holds reset long
// RULE6: Early reset release: debugger retries attach
// RULE7: Locked: debugger resets first to be seen
// RULE8: Chip erase clears the security lock
// RULE9: Erase wipes volatile memories and flash outside the auxiliary and user rows
// RULE10: Erase leaves auxiliary and user rows alone
// RULE11: Writing one to erase bit starts erase
// RULE12: Erase request dropped while access_guard protects
// RULE13: Volatile clearing finishes before flash erase
// RULE14: Done flag in primary_status reports completion
// RULE15: Debugger should erase after cold-plug attach
// RULE16: Cold-plug attach keeps core held in reset
// RULE17: Done reads zero throughout an accepted erase
module dpce_top
	import dpce_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_en_i,
	input  wire logic por_active_i,
	input  wire logic ext_reset_n_i,
	input  wire logic swclk_i,
	input  wire logic security_lock_i,
	input  wire logic guard_protect_i,
	input  wire logic erase_wr_i,
	input  wire logic erase_bit_i,
	input  wire logic core_release_i,
	input  wire logic ram_clear_done_i,
	input  wire logic flash_erase_done_i,
	output logic      probe_attached_flag_o,
	output logic      primary_status_done_o,
	output logic      core_hold_o,
	output logic      ram_clear_start_o,
	output logic      flash_erase_start_o,
	output logic      flash_keep_aux_o,
	output logic      lock_clear_o
);
	logic        por_s;
	logic        rst_n_s;
	logic        swclk_s;
	logic        swclk_prev_q;
	logic        swclk_prev_d;
	logic        rst_n_prev_q;
	logic        rst_n_prev_d;
	logic        present_q;
	logic        present_d;
	logic        hold_q;
	logic        hold_d;
	logic        done_q;
	logic        done_d;
	logic        ram_go_q;
	logic        ram_go_d;
	logic        fl_go_q;
	logic        fl_go_d;
	logic        lclr_q;
	logic        lclr_d;
	logic        hot_evt;
	logic        cold_evt;
	logic        erase_ok;
	dpce_state_t state_q;
	dpce_state_t state_d;

	dpce_sync u_por (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.async_i(por_active_i), .sync_o(por_s));
	dpce_sync u_rst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.async_i(ext_reset_n_i), .sync_o(rst_n_s));
	dpce_sync u_clk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.async_i(swclk_i), .sync_o(swclk_s));

	// Cold attach: external reset seen released while the clock is seen low
	assign cold_evt = !por_s && !rst_n_prev_q && rst_n_s && !swclk_s; // RULE4
	// Hot attach: clock falling while running and device not locked
	assign hot_evt  = !por_s && rst_n_s && swclk_prev_q && !swclk_s
		&& !security_lock_i; // RULE3
	assign erase_ok = erase_wr_i && erase_bit_i && !guard_protect_i; // RULE11 RULE12

	always_comb begin
		swclk_prev_d = swclk_s;
		rst_n_prev_d = rst_n_s;
		present_d    = present_q;
		hold_d       = hold_q;
		if (hot_evt || cold_evt) begin
			present_d = 1'b1; // RULE1 RULE2
		end
		if (cold_evt) begin
			hold_d = 1'b1; // RULE16
		end else if (core_release_i) begin
			hold_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			swclk_prev_q <= 1'b0;
			rst_n_prev_q <= 1'b0;
			present_q    <= PRESENT_RESET;
			hold_q       <= 1'b0;
		end else if (clk_en_i) begin
			swclk_prev_q <= swclk_prev_d;
			rst_n_prev_q <= rst_n_prev_d;
			present_q    <= present_d;
			hold_q       <= hold_d;
		end
	end

	always_comb begin
		state_d  = state_q;
		done_d   = done_q;
		ram_go_d = 1'b0;
		fl_go_d  = 1'b0;
		lclr_d   = 1'b0;
		case (state_q)
			DPCE_IDLE, DPCE_DONE: begin
				if (erase_ok) begin
					state_d  = DPCE_VOLATILE;
					done_d   = 1'b0; // RULE17
					ram_go_d = 1'b1; // RULE9
				end
			end
			DPCE_VOLATILE: begin
				if (ram_clear_done_i) begin
					state_d = DPCE_FLASH; // RULE13
					fl_go_d = 1'b1; // RULE9 RULE10
				end
			end
			DPCE_FLASH: begin
				if (flash_erase_done_i) begin
					state_d = DPCE_DONE;
					done_d  = 1'b1; // RULE14
					lclr_d  = 1'b1; // RULE8
				end
			end
			default: begin
				state_d = DPCE_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q  <= DPCE_IDLE;
			done_q   <= DONE_RESET;
			ram_go_q <= 1'b0;
			fl_go_q  <= 1'b0;
			lclr_q   <= 1'b0;
		end else if (clk_en_i) begin
			state_q  <= state_d;
			done_q   <= done_d;
			ram_go_q <= ram_go_d;
			fl_go_q  <= fl_go_d;
			lclr_q   <= lclr_d;
		end
	end

	assign probe_attached_flag_o = present_q;
	assign primary_status_done_o = done_q;
	assign core_hold_o           = hold_q;
	assign ram_clear_start_o     = ram_go_q;
	assign flash_erase_start_o   = fl_go_q;
	assign flash_keep_aux_o      = 1'b1; // RULE10
	assign lock_clear_o          = lclr_q;

	property p_locked_no_hot;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && security_lock_i && !present_q && !cold_evt) |=> !present_q;
	endproperty
	a_locked_no_hot: assert property (p_locked_no_hot) else $error("hot attach while locked"); // RULE3

	property p_por_block;
		@(posedge ref_clk_i) disable iff (reset_i)
		(por_s && !present_q) |=> !present_q;
	endproperty
	a_por_block: assert property (p_por_block) else $error("attach during power-on reset"); // RULE4

	property p_attach_sets;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && (hot_evt || cold_evt)) |=> present_q;
	endproperty
	a_attach_sets: assert property (p_attach_sets) else $error("attach flag not set"); // RULE2

	property p_cold_hold;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && cold_evt) |=> core_hold_o;
	endproperty
	a_cold_hold: assert property (p_cold_hold) else $error("core not held"); // RULE16

	property p_guard_drop;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && erase_wr_i && guard_protect_i
			&& (state_q == DPCE_IDLE || state_q == DPCE_DONE)) |=> !ram_go_q && done_q == $past(done_q);
	endproperty
	a_guard_drop: assert property (p_guard_drop) else $error("guarded erase accepted"); // RULE12

	property p_start_erase;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && erase_ok && state_q == DPCE_IDLE) |=> ram_go_q && !done_q;
	endproperty
	a_start_erase: assert property (p_start_erase) else $error("erase not started"); // RULE11

	property p_order;
		@(posedge ref_clk_i) disable iff (reset_i)
		fl_go_q |-> $past(state_q) == DPCE_VOLATILE;
	endproperty
	a_order: assert property (p_order) else $error("flash before volatile"); // RULE13

	property p_done_low;
		@(posedge ref_clk_i) disable iff (reset_i)
		(state_q == DPCE_VOLATILE || state_q == DPCE_FLASH) |-> !done_q;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done high mid erase"); // RULE17

	property p_unlock;
		@(posedge ref_clk_i) disable iff (reset_i)
		(clk_en_i && state_q == DPCE_FLASH && flash_erase_done_i) |=> lock_clear_o && done_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock not cleared"); // RULE8 RULE14
endmodule
`default_nettype wire

// >>> tb/dpce_probe.sv
// Debugger probe model driving the reset and debug clock pins
`timescale 1ns/1ps
`default_nettype none
module dpce_probe (
	input  wire logic ref_clk_i,
	output logic      ext_reset_n_o,
	output logic      swclk_o
);
	initial begin
		ext_reset_n_o = 1'b1;
		swclk_o       = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Cold plug: clock held low across a long reset
	task automatic cold();
		swclk_o       = 1'b0;
		ext_reset_n_o = 1'b0;
		wait_clk(12);
		ext_reset_n_o = 1'b1;
		wait_clk(8);
		swclk_o       = 1'b1;
		wait_clk(2);
	endtask
	// Hot plug: clock falls while reset is released
	task automatic hot();
		swclk_o = 1'b0;
		wait_clk(8);
		swclk_o = 1'b1;
		wait_clk(2);
	endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for probe detection and chip erase
`timescale 1ns/1ps
`default_nettype none
module tb
	import dpce_pkg::*;
;
	logic ref_clk_i;
	logic reset_i = 1'b1, por = 1'b1, lock = 1'b1, guard = 1'b0, ewr = 1'b0;
	logic ebit = 1'b0, rel = 1'b0, rdone = 1'b0, fdone = 1'b0, cen = 1'b1;
	logic ext_n, swclk, flag, done, hold, rstart, fstart, aux, lclr;
	int   miscompares = 0;
	int   compares    = 0;
	dpce_probe P (.ref_clk_i(ref_clk_i), .ext_reset_n_o(ext_n), .swclk_o(swclk));
	dpce_top DUT (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(cen), .por_active_i(por),
		.ext_reset_n_i(ext_n), .swclk_i(swclk), .security_lock_i(lock),
		.guard_protect_i(guard), .erase_wr_i(ewr), .erase_bit_i(ebit),
		.core_release_i(rel), .ram_clear_done_i(rdone), .flash_erase_done_i(fdone),
		.probe_attached_flag_o(flag), .primary_status_done_o(done), .core_hold_o(hold),
		.ram_clear_start_o(rstart), .flash_erase_start_o(fstart),
		.flash_keep_aux_o(aux), .lock_clear_o(lclr)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	task automatic request(input logic g, input logic b, input logic go);
		guard = g;
		ebit  = b;
		pulse(ewr);
		chk(rstart, go);
		chk(done, !go);
		tick();
		chk(rstart, 1'b0);
		guard = 1'b0;
	endtask
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
	initial begin
		tick(8);
		reset_i = 1'b0;
		tick();
		chk(flag, PRESENT_RESET);
		chk(done, DONE_RESET);
		chk(hold, 1'b0);
		P.cold();
		chk(flag, 1'b0);
		por = 1'b0;
		tick(3);
		P.hot();
		chk(flag, 1'b0);
		P.cold();
		chk(flag, 1'b1);
		chk(hold, 1'b1);
		request(1'b1, 1'b1, 1'b0);
		request(1'b0, 1'b0, 1'b0);
		request(1'b0, 1'b1, 1'b1);
		pulse(ewr);
		chk(rstart, 1'b0);
		chk(fstart, 1'b0);
		pulse(rdone);
		chk(fstart, 1'b1);
		tick(4);
		chk(fstart, 1'b0);
		chk(done, 1'b0);
		cen = 1'b0;
		pulse(fdone);
		chk(done, 1'b0);
		chk(lclr, 1'b0);
		cen = 1'b1;
		pulse(fdone);
		chk(done, 1'b1);
		chk(lclr, 1'b1);
		tick();
		chk(lclr, 1'b0);
		chk(aux, 1'b1);
		pulse(rel);
		tick();
		chk(hold, 1'b0);
		reset_i = 1'b1;
		lock    = 1'b0;
		tick(8);
		reset_i = 1'b0;
		tick(3);
		chk(flag, 1'b0);
		P.hot();
		chk(flag, 1'b1);
		chk(hold, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
